// ### inc/udc_pkg.sv
package udc_pkg;

   // ------------------------------------------------------------------
   // Counter geometry and count limits
   // ------------------------------------------------------------------
   localparam int unsigned CNT_W    = 4;
   localparam logic [3:0]  BIN_MAX  = 4'hf;
   localparam logic [3:0]  DEC_MAX  = 4'h9;
   localparam logic [3:0]  CNT_ZERO = 4'h0;
   localparam logic [3:0]  CNT_ONE  = 4'h1;
   localparam logic [3:0]  CNT_RST  = 4'h0;

   // ------------------------------------------------------------------
   // Pin synchroniser bit positions
   // ------------------------------------------------------------------
   localparam int unsigned SYNC_W     = 8;
   localparam int unsigned SY_CLK     = 0;
   localparam int unsigned SY_EN_N    = 1;
   localparam int unsigned SY_DOWN    = 2;
   localparam int unsigned SY_LOAD_N  = 3;
   localparam int unsigned SY_DATA_LO = 4;
   localparam logic [7:0]  SYNC_RST   = 8'h0b;

   // ------------------------------------------------------------------
   // Register map, byte addresses on the Avalon-MM slave
   // ------------------------------------------------------------------
   localparam int unsigned AVS_AW       = 4;
   localparam logic [3:0]  REG_CTRL_OFS = 4'h0;
   localparam logic [3:0]  REG_STAT_OFS = 4'h4;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

   // Control register fields.
   localparam int unsigned CTRL_DECADE = 0;

   // Status register fields.
   localparam int unsigned ST_COUNT_LO = 0;
   localparam int unsigned ST_TC       = 4;
   localparam int unsigned ST_RIPPLE_N = 5;
   localparam int unsigned ST_DOWN     = 6;
   localparam int unsigned ST_EN_N     = 7;
   localparam int unsigned ST_LOAD_N   = 8;
   localparam int unsigned ST_DECADE   = 9;

endpackage : udc_pkg

// ### rtl/udc_avs.sv
`timescale 1ns/1ps

// Avalon-MM slave with exactly one wait state per access.
module udc_avs
   import udc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [AVS_AW-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [31:0]       stat_word,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   output logic                   decade_mode
);

   typedef enum logic {AVS_IDLE, AVS_ACK} udc_avs_st_t;

   udc_avs_st_t state_r;
   logic        req;

   assign req = avs_read | avs_write;

   // ------------------------------------------------------------------
   // Handshake sequencing
   // ------------------------------------------------------------------
   // A request seen in idle is answered on the next edge, then idle again.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= AVS_IDLE;
      end else begin
         unique case (state_r)
            AVS_IDLE: if (req) state_r <= AVS_ACK;
            AVS_ACK:  state_r <= AVS_IDLE;
         endcase
      end
   end

   // Waitrequest drops for the single acknowledge cycle only.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((state_r == AVS_IDLE) && req);
      end
   end

   // Read data is captured ahead and stands at the accepting edge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= RD_ZERO;
      end else if ((state_r == AVS_IDLE) && avs_read) begin
         if (avs_address == REG_CTRL_OFS) begin
            avs_readdata <= {31'h0000_0000, decade_mode};
         end else if (avs_address == REG_STAT_OFS) begin
            avs_readdata <= stat_word;
         end else begin
            avs_readdata <= RD_ZERO;  // Unmapped reads return zero.
         end
      end
   end

   // Writes commit only at the edge where waitrequest is seen low.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         decade_mode <= CTRL_RST[CTRL_DECADE];
      end else if ((state_r == AVS_ACK) && avs_write &&
                   (avs_address == REG_CTRL_OFS)) begin
         decade_mode <= avs_writedata[CTRL_DECADE];
      end
   end

endmodule : udc_avs

// ### rtl/udc_counter.sv
`timescale 1ns/1ps

module udc_counter
   import udc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              cnt_clk,
   input  wire logic              cnt_en_n,
   input  wire logic              cnt_down,
   input  wire logic              load_n,
   input  wire logic [CNT_W-1:0]  load_data,
   output logic      [CNT_W-1:0]  count_q,
   output logic                   term_cnt,
   output logic                   ripple_n,
   input  wire logic [AVS_AW-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest
);

   logic [SYNC_W-1:0] pins_s;
   logic              s_clk;
   logic              s_en_n;
   logic              s_down;
   logic              s_load_n;
   logic [CNT_W-1:0]  s_data;
   logic              s_clk_d_r;
   logic              cnt_rise;
   logic              decade_mode;
   logic [CNT_W-1:0]  top_val;
   logic [CNT_W-1:0]  count_nxt;
   logic              term_nxt;
   logic [31:0]       stat_word;

   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   udc_sync u_sync (
      .clk      (clk),
      .reset    (reset),
      .pin_in   ({load_data, load_n, cnt_down, cnt_en_n, cnt_clk}),
      .pin_sync (pins_s)
   );

   assign s_clk    = pins_s[SY_CLK];
   assign s_en_n   = pins_s[SY_EN_N];
   assign s_down   = pins_s[SY_DOWN];
   assign s_load_n = pins_s[SY_LOAD_N];
   assign s_data   = pins_s[SY_DATA_LO +: CNT_W];

   // ------------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------------
   udc_avs u_avs (
      .clk             (clk),
      .reset           (reset),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .stat_word       (stat_word),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .decade_mode     (decade_mode)
   );

   // Status word shows the live counter state to software.
   always_comb begin
      stat_word                           = RD_ZERO;
      stat_word[ST_COUNT_LO +: CNT_W]     = count_q;
      stat_word[ST_TC]                    = term_cnt;
      stat_word[ST_RIPPLE_N]              = ripple_n;
      stat_word[ST_DOWN]                  = s_down;
      stat_word[ST_EN_N]                  = s_en_n;
      stat_word[ST_LOAD_N]                = s_load_n;
      stat_word[ST_DECADE]                = decade_mode;
   end

   // ------------------------------------------------------------------
   // Count clock edge detection
   // ------------------------------------------------------------------
   // Edge is taken from the second synchroniser stage and its delay.
   // A count clock pulse shorter than two system clocks can be lost; the
   // pin rate is bounded by the synchroniser, not by the count logic.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_clk_d_r <= SYNC_RST[SY_CLK];
      end else begin
         s_clk_d_r <= s_clk;
      end
   end

   assign cnt_rise = s_clk & ~s_clk_d_r;

   // ------------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------------
   assign top_val = decade_mode ? DEC_MAX : BIN_MAX;

   // Enable and direction are sampled at the edge; they are steady
   // because the driver only moves them while the count clock is high.
   always_comb begin
      count_nxt = count_q;
      if (!s_load_n) begin
         count_nxt = s_data;
      end else if (cnt_rise && !s_en_n) begin
         if (!s_down) begin
            // Decade mode also folds illegal codes above nine back to zero.
            if (count_q >= top_val) begin
               count_nxt = CNT_ZERO;
            end else begin
               count_nxt = count_q + CNT_ONE;
            end
         end else begin
            if (count_q == CNT_ZERO) begin
               count_nxt = top_val;
            end else begin
               count_nxt = count_q - CNT_ONE;
            end
         end
      end
   end

   // One register holds all four bits, so they switch together.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= CNT_RST;
      end else begin
         count_q <= count_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Cascade outputs
   // ------------------------------------------------------------------
   // The flag follows the held count, so it lasts one count period.
   // It is not gated by the enable, so a look-ahead cascade must still
   // combine it with its own enable.
   assign term_nxt = s_down ? (count_q == CNT_ZERO) : (count_q == top_val);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         term_cnt <= 1'b0;
      end else begin
         term_cnt <= term_nxt;
      end
   end

   // Ripple is the flag gated by the enable and the count clock low
   // phase; it lags the pins by the synchroniser latency plus one clock.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ripple_n <= 1'b1;
      end else begin
         ripple_n <= ~(term_cnt & ~s_en_n & ~s_clk);
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   count_up_a: assert property (
      @(posedge clk) disable iff (reset)
      (cnt_rise && !s_en_n && s_load_n && !s_down && count_q < top_val)
      |=> (count_q == CNT_W'($past(count_q) + CNT_ONE)))
      else $error("Enabled up edge did not add one.");

   count_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      (s_en_n && s_load_n) |=> $stable(count_q))
      else $error("Count moved while enable was high.");

   count_down_a: assert property (
      @(posedge clk) disable iff (reset)
      (cnt_rise && !s_en_n && s_load_n && s_down && count_q != CNT_ZERO)
      |=> (count_q == CNT_W'($past(count_q) - CNT_ONE)))
      else $error("Enabled down edge did not subtract one.");

   preset_load_a: assert property (
      @(posedge clk) disable iff (reset)
      !s_load_n |=> (count_q == $past(s_data)))
      else $error("Count did not follow data while load low.");

   term_flag_a: assert property (
      @(posedge clk) disable iff (reset)
      (s_down && count_q == CNT_ZERO) ##1 $stable(s_down)
      |-> term_cnt)
      else $error("Terminal flag missing at zero counting down.");

   ripple_gate_a: assert property (
      @(posedge clk) disable iff (reset)
      !ripple_n |-> $past(term_cnt) && !$past(s_en_n) && !$past(s_clk))
      else $error("Ripple low without its gating terms.");

   decade_wrap_a: assert property (
      @(posedge clk) disable iff (reset)
      (decade_mode && cnt_rise && !s_en_n && s_load_n && !s_down &&
       count_q == DEC_MAX) |=> (count_q == CNT_ZERO))
      else $error("Decade count did not wrap from nine to zero.");

   decade_range_a: assert property (
      @(posedge clk) disable iff (reset)
      (decade_mode && $stable(decade_mode) && s_load_n &&
       count_q <= DEC_MAX) |=> (count_q <= DEC_MAX))
      else $error("Decade count left the ten decimal states.");

   // ------------------------------------------------------------------
   // Wrap, cascade and bus checks
   // ------------------------------------------------------------------
   // Each end point of the count and each cascade term is pinned down
   // on its own, so a slip in the limit logic cannot hide on one side
   // of the wrap while the other side still looks right.

   term_up_a: assert property (
      @(posedge clk) disable iff (reset)
      (!s_down && count_q == top_val)
      |=> term_cnt)
      else $error("Terminal flag missing at the top counting up.");

   term_off_up_a: assert property (
      @(posedge clk) disable iff (reset)
      (!s_down && count_q != top_val)
      |=> !term_cnt)
      else $error("Terminal flag high below the top counting up.");

   term_off_down_a: assert property (
      @(posedge clk) disable iff (reset)
      (s_down && count_q != CNT_ZERO)
      |=> !term_cnt)
      else $error("Terminal flag high above zero counting down.");

   ripple_low_a: assert property (
      @(posedge clk) disable iff (reset)
      (term_cnt && !s_en_n && !s_clk)
      |=> !ripple_n)
      else $error("Ripple stayed high in a terminal low phase.");

   ripple_clk_a: assert property (
      @(posedge clk) disable iff (reset)
      s_clk
      |=> ripple_n)
      else $error("Ripple low while the count clock was high.");

   ripple_en_a: assert property (
      @(posedge clk) disable iff (reset)
      s_en_n
      |=> ripple_n)
      else $error("Ripple low while counting was disabled.");

   bin_wrap_up_a: assert property (
      @(posedge clk) disable iff (reset)
      (!decade_mode && cnt_rise && !s_en_n && s_load_n && !s_down &&
       count_q == BIN_MAX) |=> (count_q == CNT_ZERO))
      else $error("Binary count did not wrap from fifteen to zero.");

   bin_wrap_down_a: assert property (
      @(posedge clk) disable iff (reset)
      (!decade_mode && cnt_rise && !s_en_n && s_load_n && s_down &&
       count_q == CNT_ZERO) |=> (count_q == BIN_MAX))
      else $error("Binary count did not wrap from zero to fifteen.");

   dec_wrap_down_a: assert property (
      @(posedge clk) disable iff (reset)
      (decade_mode && cnt_rise && !s_en_n && s_load_n && s_down &&
       count_q == CNT_ZERO) |=> (count_q == DEC_MAX))
      else $error("Decade count did not wrap from zero to nine.");

   edge_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      (s_load_n && !cnt_rise)
      |=> $stable(count_q))
      else $error("Count moved without a count clock edge.");

   ack_prompt_a: assert property (
      @(posedge clk) disable iff (reset)
      (avs_read || avs_write)
      |-> ##[0:2] !avs_waitrequest)
      else $error("Bus request was not answered in time.");

   wr_commit_a: assert property (
      @(posedge clk) disable iff (reset)
      (!avs_waitrequest && avs_write && avs_address == REG_CTRL_OFS)
      |=> (decade_mode == $past(avs_writedata[CTRL_DECADE])))
      else $error("Control write did not set the variant.");

   rd_ctrl_a: assert property (
      @(posedge clk) disable iff (reset)
      (!avs_waitrequest && avs_read && avs_address == REG_CTRL_OFS)
      |-> (avs_readdata[31:1] == 31'h0000_0000 &&
           avs_readdata[CTRL_DECADE] == decade_mode))
      else $error("Control read did not show the variant.");

endmodule : udc_counter

// ### rtl/udc_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for every pin; the first stage feeds only the
// second one, so metastability never reaches decision logic.
module udc_sync
   import udc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [SYNC_W-1:0] pin_in,
   output logic      [SYNC_W-1:0] pin_sync
);

   logic [SYNC_W-1:0] meta_r;

   // ------------------------------------------------------------------
   // Per-bit double flop
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
         // Reset values mirror the idle pin levels to avoid false events.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               meta_r[gi]   <= SYNC_RST[gi];
               pin_sync[gi] <= SYNC_RST[gi];
            end else begin
               meta_r[gi]   <= pin_in[gi];
               pin_sync[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

endmodule : udc_sync

// ### test/udc_counter_bench.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Self-checking bench: count pins through the model, preset pins direct, registers over Avalon
// ------------------------------------------------------------------
module udc_counter_bench
   import udc_pkg::*;
;
   logic        clk;
   logic        reset;
   logic        go;
   logic        en_n_want;
   logic        down_want;
   logic        cnt_clk;
   logic        cnt_en_n;
   logic        cnt_down;
   logic        busy;
   logic        load_n;
   logic [3:0]  load_data;
   logic [3:0]  count_q;
   logic        term_cnt;
   logic        ripple_n;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [31:0] rd;
   logic        saw_rip;
   int          fails;
   int          n_tests;

   udc_counter uut (.clk(clk), .reset(reset), .cnt_clk(cnt_clk),
      .cnt_en_n(cnt_en_n), .cnt_down(cnt_down), .load_n(load_n),
      .load_data(load_data), .count_q(count_q), .term_cnt(term_cnt),
      .ripple_n(ripple_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   udc_pin_model pins (.clk(clk), .reset(reset), .go(go),
      .en_n_want(en_n_want), .down_want(down_want), .ripple_n(ripple_n),
      .term_cnt(term_cnt), .cnt_clk(cnt_clk), .cnt_en_n(cnt_en_n),
      .cnt_down(cnt_down), .busy(busy), .next_en_n(), .look_en_n());

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Remember any low ripple level seen during a pulse.
   always @(posedge clk) begin
      if (ripple_n === 1'b0) saw_rip = 1'b1;
   end

   task automatic results;
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask : chk

   // One Avalon access; held until waitrequest is sampled low.
   task automatic avs_xfer(input logic wr, input logic [3:0] a,
                           input logic [31:0] d, output logic [31:0] q);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : avs_xfer

   // Hold the preset strobe low long enough to pass the synchroniser.
   task automatic preset(input logic [3:0] v);
      load_data <= v;
      load_n    <= 1'b0;
      repeat (6) @(posedge clk);
      load_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk(count_q, v, "preset");
   endtask : preset

   // One count clock pulse, then the resulting pin state is checked.
   task automatic step(input logic en_n, input logic dn,
                       input logic [3:0] c, input logic t,
                       input logic r);
      int k;
      en_n_want <= en_n;
      down_want <= dn;
      repeat (4) @(posedge clk);
      saw_rip = 1'b0;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 40 && busy === 1'b1; k++) @(posedge clk);
      repeat (6) @(posedge clk);
      chk(count_q, c, "count");
      chk(term_cnt, t, "terminal");
      chk(saw_rip, r, "ripple");
   endtask : step

   // Watchdog, far beyond the few hundred clocks that the run takes.
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      results();
   end

   // Main sequence.
   initial begin
      reset = 1'b1;
      go = 1'b0;
      en_n_want = 1'b1;
      down_want = 1'b0;
      load_n = 1'b1;
      load_data = 4'h0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      fails = 0;
      n_tests = 0;
      saw_rip = 1'b0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      chk(count_q, CNT_RST, "reset count");
      chk({term_cnt, ripple_n}, 2'b01, "reset flags");
      avs_xfer(1'b0, REG_CTRL_OFS, 32'h0000_0000, rd);
      chk(rd, CTRL_RST, "ctrl reset");
      avs_xfer(1'b1, 4'h8, 32'hffff_ffff, rd);
      avs_xfer(1'b0, 4'h8, 32'h0000_0000, rd);
      chk(rd, RD_ZERO, "unmapped");
      preset(4'he);
      step(1'b0, 1'b0, 4'hf, 1'b1, 1'b0);
      step(1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
      step(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
      step(1'b0, 1'b1, 4'hf, 1'b0, 1'b1);
      step(1'b0, 1'b1, 4'he, 1'b0, 1'b0);
      avs_xfer(1'b0, REG_STAT_OFS, 32'h0000_0000, rd);
      chk(rd[9:0], 10'h16e, "status binary");
      avs_xfer(1'b1, REG_CTRL_OFS, 32'h0000_0001, rd);
      avs_xfer(1'b0, REG_CTRL_OFS, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0001, "ctrl readback");
      preset(4'h8);
      step(1'b0, 1'b0, 4'h9, 1'b1, 1'b0);
      step(1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
      step(1'b0, 1'b1, 4'h9, 1'b0, 1'b1);
      avs_xfer(1'b0, REG_STAT_OFS, 32'h0000_0000, rd);
      chk(rd[9:0], 10'h369, "status decade");
      results();
   end
endmodule : udc_counter_bench

// ### test/udc_pin_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Control logic and next stage on the pin side of the counter
// ------------------------------------------------------------------
// Makes one count clock pulse per request. The clock idles high, so
// enable and direction are only ever changed while it is high.
module udc_pin_model
   import udc_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic go,
   input  wire logic en_n_want,
   input  wire logic down_want,
   input  wire logic ripple_n,
   input  wire logic term_cnt,
   output logic      cnt_clk,
   output logic      cnt_en_n,
   output logic      cnt_down,
   output logic      busy,
   output logic      next_en_n,
   output logic      look_en_n
);
   logic [3:0] phase_r;

   // Low phase and high phase are four clocks each, well above the
   // two clocks that the two-flop synchronisers need to see a level.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_r <= 4'h0;
         cnt_clk <= 1'b1;
      end else if (phase_r == 4'h0) begin
         if (go) begin
            phase_r <= 4'h1;
            cnt_clk <= 1'b0;
         end
      end else begin
         phase_r <= (phase_r == 4'h8) ? 4'h0 : phase_r + 4'h1;
         if (phase_r == 4'h4) begin
            cnt_clk <= 1'b1;
         end
      end
   end

   // Levels move only when idle, which is always in the high phase.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_en_n <= 1'b1;
         cnt_down <= 1'b0;
      end else if (phase_r == 4'h0 && !go) begin
         cnt_en_n <= en_n_want;
         cnt_down <= down_want;
      end
   end

   // Busy flag to the bench and cascade outputs towards a following stage.
   assign busy      = (phase_r != 4'h0);
   assign next_en_n = ripple_n;
   assign look_en_n = ~term_cnt;
endmodule : udc_pin_model
